/* File: src/irq_enable_clear_regs.sv */
// enable mask registers with set and clear views, gating source requests
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE1] writing one to clear bit disables source
// [RULE2] writing zero to clear bit changes nothing
// [RULE3] reads return current enable flags
// [RULE4] low word holds sources 0 to 31
// [RULE5] high clear word decoded at own address
// [RULE6] low word: port0 0-11, port1 0-11, port2 0-7
// [RULE7] high bits 0-7: port2 8-11, port3 0-3
// [RULE8] high bits 8-19: peripheral interrupts in order
// [RULE9] high bits 21-24 gpio ports 3..0, 25 serial1
// [RULE10] software writes no ones to reserved bits
// [RULE11] reserved bits read as don't care
// [RULE12] set words share flags, ones set them
// [RULE13] flags reset disabled, disabled requests masked
module irq_enable_clear_regs
  import irq_enable_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [11:0] wake_port0,
  input  wire logic [11:0] wake_port1,
  input  wire logic [11:0] wake_port2,
  input  wire logic [3:0]  wake_port3,
  input  wire logic        two_wire_zero,
  input  wire logic        timer16_zero,
  input  wire logic        timer16_one,
  input  wire logic        timer32_zero,
  input  wire logic        timer32_one,
  input  wire logic        sync_serial_zero,
  input  wire logic        uart_irq,
  input  wire logic        usb_normal_irq,
  input  wire logic        usb_frame_irq,
  input  wire logic        converter_irq,
  input  wire logic        watchdog_irq,
  input  wire logic        brownout_irq,
  input  wire logic [3:0]  gpio_port_irq,
  input  wire logic        sync_serial_one,
  output logic      [63:0] gated_request,
  output logic      [63:0] enable_state
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  // exact word match only; anything else reads zero and writes nothing
  function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
    hit = (a == target);
  endfunction : hit

  logic [31:0] enable_low;
  logic [31:0] enable_high;
  logic [63:0] raw_request;
  logic [63:0] next_gated;
  logic [31:0] next_rdata;

  // ****************************************************************
  // flag words
  // ****************************************************************
  // low word holds sources 0..31, all bits implemented
  enable_word low_word (
    .clk      (clk),
    .srst     (srst),
    .impl_mask(32'hffff_ffff),
    .set_we   (wr && hit(addr, ADDR_ENABLE_SET_LOW)),
    .clear_we (wr && hit(addr, ADDR_ENABLE_CLEAR_LOW)),  // [RULE4]
    .wdata    (wdata),
    .enable   (enable_low)
  );

  // high word at its own address; reserved bits never hold a flag, so ones
  // written there by misbehaving software are simply dropped
  enable_word high_word (
    .clk      (clk),
    .srst     (srst),
    .impl_mask(HIGH_IMPL_MASK),  // [RULE10]
    .set_we   (wr && hit(addr, ADDR_ENABLE_SET_HIGH)),
    .clear_we (wr && hit(addr, ADDR_ENABLE_CLEAR_HIGH)),  // [RULE5]
    .wdata    (wdata),
    .enable   (enable_high)
  );

  // ****************************************************************
  // source to bit mapping
  // ****************************************************************
  always_comb begin
    raw_request = 64'h0000_0000_0000_0000;
    raw_request[BIT_WAKE_P0_0 +: 12] = wake_port0;  // [RULE6]
    raw_request[BIT_WAKE_P1_0 +: 12] = wake_port1;  // [RULE6]
    raw_request[BIT_WAKE_P2_0 +: 8]  = wake_port2[7:0];  // [RULE6]
    raw_request[NUM_LOW_SOURCES + BIT_WAKE_P2_8 +: 4] = wake_port2[11:8];  // [RULE7]
    raw_request[NUM_LOW_SOURCES + BIT_WAKE_P3_0 +: 4] = wake_port3;  // [RULE7]
    raw_request[NUM_LOW_SOURCES + BIT_TWO_WIRE_ZERO] = two_wire_zero;  // [RULE8]
    raw_request[NUM_LOW_SOURCES + BIT_TIMER16_ZERO]  = timer16_zero;
    raw_request[NUM_LOW_SOURCES + BIT_TIMER16_ONE]   = timer16_one;
    raw_request[NUM_LOW_SOURCES + BIT_TIMER32_ZERO]  = timer32_zero;
    raw_request[NUM_LOW_SOURCES + BIT_TIMER32_ONE]   = timer32_one;
    raw_request[NUM_LOW_SOURCES + BIT_SYNC_SERIAL_0] = sync_serial_zero;
    raw_request[NUM_LOW_SOURCES + BIT_UART]          = uart_irq;
    raw_request[NUM_LOW_SOURCES + BIT_USB_NORMAL]    = usb_normal_irq;
    raw_request[NUM_LOW_SOURCES + BIT_USB_FRAME]     = usb_frame_irq;
    raw_request[NUM_LOW_SOURCES + BIT_CONVERTER]     = converter_irq;
    raw_request[NUM_LOW_SOURCES + BIT_WATCHDOG]      = watchdog_irq;
    raw_request[NUM_LOW_SOURCES + BIT_BROWNOUT]      = brownout_irq;  // [RULE8]
    // gpio ports in reverse order: port 3 at the lowest bit
    for (int i = 0; i < 4; i++) begin
      raw_request[NUM_LOW_SOURCES + BIT_GPIO_PORT3 + i] = gpio_port_irq[3 - i];  // [RULE9]
    end
    raw_request[NUM_LOW_SOURCES + BIT_SYNC_SERIAL_1] = sync_serial_one;  // [RULE9]
  end

  // ****************************************************************
  // request gating and read path
  // ****************************************************************
  // a disabled source is held back from prioritisation
  always_comb begin
    next_gated = raw_request & {enable_high, enable_low};  // [RULE13]
    next_rdata = RESERVED_READ;
    if (rd) begin
      if (hit(addr, ADDR_ENABLE_CLEAR_LOW) || hit(addr, ADDR_ENABLE_SET_LOW)) begin
        next_rdata = enable_low;  // [RULE3]
      end else if (hit(addr, ADDR_ENABLE_CLEAR_HIGH) || hit(addr, ADDR_ENABLE_SET_HIGH)) begin
        // reserved bits come back as zero; callers may not rely on that
        next_rdata = enable_high;  // [RULE3] [RULE11]
      end
    end
  end

  // registered outputs; gating costs one cycle of request latency
  always_ff @(posedge clk) begin
    if (srst) begin
      gated_request <= 64'h0000_0000_0000_0000;
      rdata         <= 32'h0000_0000;
    end else begin
      gated_request <= next_gated;
      rdata         <= next_rdata;
    end
  end

  assign enable_state = {enable_high, enable_low};

endmodule : irq_enable_clear_regs

`default_nettype wire

/* File: src/irq_enable_pkg.sv */
// package of register offsets, field positions and reset values for the enable mask block
package irq_enable_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [31:0] ADDR_ENABLE_SET_LOW    = 32'he000_e100;
  localparam logic [31:0] ADDR_ENABLE_SET_HIGH   = 32'he000_e104;
  localparam logic [31:0] ADDR_ENABLE_CLEAR_LOW  = 32'he000_e180;
  localparam logic [31:0] ADDR_ENABLE_CLEAR_HIGH = 32'he000_e184;

  // ****************************************************************
  // source numbering and field layout
  // ****************************************************************
  localparam int          NUM_LOW_SOURCES  = 32;
  localparam int          NUM_HIGH_SOURCES = 32;
  localparam int          NUM_SOURCES      = 64;
  // implemented bits of the high word: 25:21 and 19:0
  localparam logic [31:0] HIGH_IMPL_MASK   = 32'h03ef_ffff;
  localparam logic [31:0] RESERVED_READ    = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;

  // bit positions in the high word
  localparam int BIT_WAKE_P2_8      = 0;
  localparam int BIT_WAKE_P3_0      = 4;
  localparam int BIT_TWO_WIRE_ZERO  = 8;
  localparam int BIT_TIMER16_ZERO   = 9;
  localparam int BIT_TIMER16_ONE    = 10;
  localparam int BIT_TIMER32_ZERO   = 11;
  localparam int BIT_TIMER32_ONE    = 12;
  localparam int BIT_SYNC_SERIAL_0  = 13;
  localparam int BIT_UART           = 14;
  localparam int BIT_USB_NORMAL     = 15;
  localparam int BIT_USB_FRAME      = 16;
  localparam int BIT_CONVERTER      = 17;
  localparam int BIT_WATCHDOG       = 18;
  localparam int BIT_BROWNOUT       = 19;
  localparam int BIT_GPIO_PORT3     = 21;
  localparam int BIT_GPIO_PORT0     = 24;
  localparam int BIT_SYNC_SERIAL_1  = 25;
  // bit positions in the low word
  localparam int BIT_WAKE_P0_0      = 0;
  localparam int BIT_WAKE_P1_0      = 12;
  localparam int BIT_WAKE_P2_0      = 24;

endpackage : irq_enable_pkg

/* File: src/enable_word.sv */
// one 32-bit word of enable flags with set and clear write ports
`timescale 1ns/1ns
`default_nettype none

module enable_word
  import irq_enable_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [31:0] impl_mask,
  input  wire logic        set_we,
  input  wire logic        clear_we,
  input  wire logic [31:0] wdata,
  output logic      [31:0] enable
);

  logic [31:0] next_enable;

  // ****************************************************************
  // flag update
  // ****************************************************************
  // ones set or clear, zeros leave the flag alone; unimplemented bits stay 0
  always_comb begin
    next_enable = enable;
    if (set_we) begin
      next_enable = enable | (wdata & impl_mask);  // [RULE12]
    end
    if (clear_we) begin
      next_enable = enable & ~wdata;  // [RULE1] [RULE2]
    end
    next_enable = next_enable & impl_mask;
  end

  // all sources start disabled
  always_ff @(posedge clk) begin
    if (srst) begin
      enable <= ENABLE_RESET;  // [RULE13]
    end else begin
      enable <= next_enable;
    end
  end

endmodule : enable_word

`default_nettype wire

/* File: verif/enable_props.sv */
// checker for the enable mask register bus and request gating
`timescale 1ns/1ns
`default_nettype none
module enable_props
  import irq_enable_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [31:0] rdata,
  input  wire logic [63:0] gated_request,
  input  wire logic [63:0] enable_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ****
  // bus effects, one cycle after the strobe
  // ****
  AST_CLR_LOW: assert property (wr && addr == ADDR_ENABLE_CLEAR_LOW |=> (enable_state[31:0] & $past(wdata)) == 0)
    else $error("clear low left a flag set");
  AST_KEEP_LOW: assert property (wr && addr == ADDR_ENABLE_CLEAR_LOW |=>
    enable_state[31:0] == ($past(enable_state[31:0]) & ~$past(wdata))) else $error("clear low disturbed flags");
  AST_CLR_HIGH: assert property (wr && addr == ADDR_ENABLE_CLEAR_HIGH |=>
    enable_state[63:32] == ($past(enable_state[63:32]) & ~$past(wdata))) else $error("clear high wrong");
  AST_SET_LOW: assert property (wr && addr == ADDR_ENABLE_SET_LOW |=>
    enable_state[31:0] == ($past(enable_state[31:0]) | $past(wdata))) else $error("set low wrong");
  AST_RD_LOW: assert property (rd && addr == ADDR_ENABLE_CLEAR_LOW |=> rdata == $past(enable_state[31:0]))
    else $error("read low wrong");
  // reserved read bits are left out on purpose
  AST_RD_HIGH: assert property (rd && addr == ADDR_ENABLE_CLEAR_HIGH |=>
    (rdata & HIGH_IMPL_MASK) == ($past(enable_state[63:32]) & HIGH_IMPL_MASK)) else $error("read high wrong");
  AST_IDLE_RD: assert property (!rd |=> rdata == 32'h0000_0000) else $error("read data outside its cycle");
  AST_NO_WR: assert property (!wr |=> $stable(enable_state)) else $error("flags moved without a write");
  AST_GATE: assert property (1'b1 |-> (gated_request & ~$past(enable_state)) == 0)
    else $error("disabled source forwarded");
  C_CLR_HIGH: cover property (wr && addr == ADDR_ENABLE_CLEAR_HIGH);
  C_RD_LOW: cover property (rd && addr == ADDR_ENABLE_CLEAR_LOW);
  C_GATED: cover property (|gated_request);
endmodule : enable_props
`default_nettype wire

/* File: verif/core_bus_model.sv */
// processor side model issuing single-cycle register strobes
`timescale 1ns/1ns
`default_nettype none
module core_bus_model
  import irq_enable_pkg::*;
(
  output logic [31:0] addr,
  output logic [31:0] wdata,
  output logic        wr,
  output logic        rd
);
  // ****
  // bus cycle
  // ****
  // called right after an edge; no wait states, so one call is one cycle
  task automatic issue(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= a[2] ? (d & HIGH_IMPL_MASK) : d;
  endtask : issue
endmodule : core_bus_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench: random register traffic and request levels
`timescale 1ns/1ns
`default_nettype none
module testbench
  import irq_enable_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] addr, wdata, rdata;
  logic        wr, rd;
  logic [63:0] raw = 64'h0, gated_request, enable_state, exp_en = 64'h0, exp_gate, exp_rd;
  int          bad_count = 0, n_tests = 0;
  logic [31:0] amap [5] = '{ADDR_ENABLE_SET_LOW, ADDR_ENABLE_SET_HIGH, ADDR_ENABLE_CLEAR_LOW,
                            ADDR_ENABLE_CLEAR_HIGH, 32'he000_e188};
  // corner ops {wr, rd, addr, data}: boundary bits, zero clears, unmapped place
  logic [65:0] corner [6] = '{{2'b10, ADDR_ENABLE_SET_LOW, 32'hffff_ffff}, {2'b10, ADDR_ENABLE_SET_HIGH, 32'hffff_ffff},
    {2'b10, ADDR_ENABLE_CLEAR_LOW, 32'h0000_0000}, {2'b10, ADDR_ENABLE_CLEAR_HIGH, 32'h0200_0001},
    {2'b10, 32'he000_e188, 32'hffff_ffff}, {2'b01, ADDR_ENABLE_CLEAR_HIGH, 32'h0000_0000}};
  always #25 clk = ~clk;
  core_bus_model host (.addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  irq_enable_clear_regs uut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .wake_port0(raw[11:0]), .wake_port1(raw[23:12]), .wake_port2({raw[35:32], raw[31:24]}), .wake_port3(raw[39:36]),
    .two_wire_zero(raw[40]), .timer16_zero(raw[41]), .timer16_one(raw[42]), .timer32_zero(raw[43]),
    .timer32_one(raw[44]), .sync_serial_zero(raw[45]), .uart_irq(raw[46]), .usb_normal_irq(raw[47]),
    .usb_frame_irq(raw[48]), .converter_irq(raw[49]), .watchdog_irq(raw[50]), .brownout_irq(raw[51]),
    .gpio_port_irq({raw[53], raw[54], raw[55], raw[56]}), .sync_serial_one(raw[57]),
    .gated_request(gated_request), .enable_state(enable_state));
  // ****
  // expectation and reporting
  // ****
  function automatic logic [63:0] next_en(input logic [63:0] e, input logic [31:0] a, input logic [31:0] d);
    case (a)
      ADDR_ENABLE_SET_LOW:    e[31:0]  = e[31:0] | d;
      ADDR_ENABLE_SET_HIGH:   e[63:32] = e[63:32] | (d & HIGH_IMPL_MASK);
      ADDR_ENABLE_CLEAR_LOW:  e[31:0]  = e[31:0] & ~d;
      ADDR_ENABLE_CLEAR_HIGH: e[63:32] = e[63:32] & ~d;
      default: ;
    endcase
    return e;
  endfunction : next_en
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // one op per cycle; quiet around each reset so no access hits the release edge
  initial begin
    logic [31:0] a;
    logic        w;
    void'($urandom(33257));
    host.issue(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      exp_rd   = (rd && !srst && addr != 32'he000_e188) ? {32'h0, addr[2] ? exp_en[63:32] : exp_en[31:0]} : 64'h0;
      exp_gate = srst ? 64'h0 : raw & exp_en;
      exp_en   = srst ? 64'h0 : wr ? next_en(exp_en, addr, wdata) : exp_en;
      srst <= (i == 0 || i == 300);
      raw  <= {$urandom, $urandom};
      a = amap[$urandom_range(0, 4)];
      if (i < 2 || i == 300 || i == 301) host.issue(1'b0, 1'b0, a, 32'h0000_0000);
      else if (i < 8) host.issue(corner[i-2][65], corner[i-2][64], corner[i-2][63:32], corner[i-2][31:0]);
      else begin
        // draw the write strobe first so read and write never share a cycle
        w = ($urandom_range(0, 1) == 1);
        host.issue(w, !w && ($urandom_range(0, 2) == 0), a, $urandom);
      end
      @(negedge clk);
      chk(enable_state, exp_en);
      chk({32'h0, rdata}, exp_rd);
      chk({32'h0, gated_request[31:0]}, {32'h0, exp_gate[31:0]});
      chk({gated_request[63:32], 32'h0}, {exp_gate[63:32], 32'h0});
    end
    end_sim();
  end
endmodule : testbench
bind irq_enable_clear_regs enable_props props (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .gated_request(gated_request), .enable_state(enable_state));
`default_nettype wire
